/* pkg/hmap_pkg.sv */
package hmap_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int MEM_AW = 16;
   localparam int BANKS = 4;
   localparam int FIFO_DEPTH = 32;
   localparam int PIN_W = ADDR_W + DATA_W + 4;
   localparam logic [PIN_W-1:0] PIN_IDLE = {4'hF, 50'h0};
   localparam logic [15:0] MEM_SPACE_BASE = 16'h0400;
   localparam logic [15:0] PLATFORM_OFS = 16'h0300;
   localparam logic [15:0] INT_STATUS_OFS = 16'h0310;
   localparam logic [15:0] DMA_CFG_OFS = 16'h0330;
   localparam logic [15:0] DMA_START_OFS = 16'h0334;
   localparam logic [15:0] DMA_STATUS_OFS = 16'h0338;
   localparam logic [15:0] PREFETCH_OFS = 16'h033C;
   localparam int BUS32_BIT = 8;
   localparam int DMA_REQUEST_POL_BIT = 5;
   localparam int DMA_GRANT_POL_BIT = 6;
   localparam int DMA_DIR_BIT = 0;
   localparam int DMA_EN_BIT = 1;
   localparam int BURST_LSB = 2;
   localparam int LEN_LSB = 16;
   localparam int DONE_BIT = 3;
   localparam logic [31:0] PLATFORM_RST = 32'h0000_0000;
   localparam logic [31:0] DMA_CFG_RST = 32'h0000_0000;
   localparam logic DMA_REQUEST_PIN_RST = 1'b1;
   localparam logic [15:0] STEP32 = 16'h0004;
   localparam logic [15:0] STEP16 = 16'h0002;
   localparam logic [5:0] BURST_1 = 6'h01;
   localparam logic [5:0] BURST_4 = 6'h04;
   localparam logic [5:0] BURST_8 = 6'h08;
   localparam logic [5:0] BURST_16 = 6'h10;
   localparam logic [2:0] SRC_DMA = 3'h4;
   typedef enum {MEM_IDLE, MEM_WAIT} mem_state_e;
   typedef struct packed {
      logic [15:0] addr;
      logic [3:0] be;
      logic [31:0] data;
   } wr_item_s;
endpackage : hmap_pkg

/* pkg/fifo_if.sv */
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 52);
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;
   modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
   modport fill (output push_valid, push_data, input push_ready);
   modport drain (input pop_valid, pop_data, output pop_ready);
endinterface : fifo_if

/* core/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 52,
   parameter int DEPTH = 32
) (
   input wire logic clk_in,
   input wire logic rst_in,
   fifo_if.store q
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic [AW:0] count;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("word_fifo depth must be a power of two of at least two.");
   end
   if (WIDTH != $bits(q.push_data)) begin : g_bad_width
      $error("word_fifo width does not match its interface.");
   end

   assign count = wr_ptr_reg - rd_ptr_reg;
   assign q.push_ready = (count != DEPTH[AW:0]);
   assign q.pop_valid = (count != '0);
   assign q.pop_data = mem_reg[rd_ptr_reg[AW-1:0]];
   assign push = q.push_valid && q.push_ready;
   assign pop = q.pop_valid && q.pop_ready;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   // Storage carries no reset; only the pointers decide what is valid.
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= q.push_data;
      end
   end
endmodule : word_fifo

/* core/host_memory_access_port.sv */
`timescale 1ns/1ps
// Function
// RULE1 - One bit selects 16- or 32-bit bus.
// RULE2 - Processor keeps accesses aligned to bus width.
// RULE3 - 16-bit register access needs both halves.
// RULE4 - Chip select for PIO, grant for DMA.
// RULE5 - Processor loads prefetch pointer before reading.
// RULE6 - Per-bank read pointers advance per read.
// RULE7 - Prefetch applies only to buffer memory space.
// RULE8 - Interleaved bank reads resume where stopped.
// RULE9 - Memory writes use bus address every cycle.
// RULE10 - Register accesses decode bus address each time.
// RULE11 - DMA bursts of 1, 4, 8, 16 cycles.
// RULE12 - Request drops on last strobe, then returns.
// RULE13 - Request stays off after count exhausted.
// RULE14 - Request and grant polarity are programmable.
// RULE15 - Accesses between bursts leave DMA state alone.
// RULE16 - System starts DMA on an aligned address.
// RULE17 - No end pin; done flag set instead.
// RULE18 - Burst bytes; 16-bit needs twice the cycles.
// RULE19 - Odd lengths: only specified bytes are written.
// RULE20 - Enabling DMA raises the request at once.
// RULE21 - System DMA may start without request.
// RULE22 - One DMA at a time, PIO alongside.
// RULE23 - PIO copies use prefetch, raise no done.
module host_memory_access_port #(
   parameter int FIFO_DEPTH = hmap_pkg::FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [hmap_pkg::ADDR_W-1:0] addr_in,
   input wire logic [hmap_pkg::DATA_W-1:0] data_in,
   output logic [hmap_pkg::DATA_W-1:0] data_out,
   output logic data_oe_out,
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic dma_grant_in,
   output logic dma_request_out,
   output logic dma_done_event_flag_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [hmap_pkg::MEM_AW-1:0] mem_addr_out,
   output logic [hmap_pkg::DATA_W-1:0] mem_wdata_out,
   output logic [3:0] mem_be_out,
   input wire logic mem_ack_in,
   input wire logic [hmap_pkg::DATA_W-1:0] mem_rdata_in
);
   import hmap_pkg::*;

   if (FIFO_DEPTH < 16) begin : g_bad_fifo
      $error("Write queue must hold at least one full burst.");
   end

   logic [PIN_W-1:0] pin_raw, s1_reg, s2_reg, s3_reg, filt_reg;
   logic [17:0] f_addr;
   logic [31:0] f_data;
   logic rd_act, wr_act, rd_prev_reg, wr_prev_reg, rd_start, wr_start;
   logic bus32, grant_act, pio_sel, mem_space;
   logic [1:0] bank;
   logic [15:0] step;
   logic pio_rd_mem, pio_rd_reg, pio_wr_mem, pio_wr_reg;
   logic [31:0] platform_reg, dma_cfg_reg, int_status_reg, reg_rdata, reg_wr_data;
   logic [15:0] dma_start_reg, hold_reg, snap_reg, reg_wr_ofs, reg_ofs;
   logic [17:0] pf_cfg_reg;
   logic reg_wr_en, dma_go, dma_abort;
   logic [15:0] pf_ptr_reg [BANKS];
   logic [31:0] pf_data_reg [BANKS];
   logic [BANKS-1:0] pf_valid_reg, pf_loaded_reg;
   logic [15:0] dma_ptr_reg, dma_left_reg, dma_take;
   logic dma_armed_reg, req_on_reg, req_on_next, dma_beat, dma_dir_rd, last_in_burst, dma_final;
   logic [5:0] dma_beat_reg, burst_cycles;
   logic [31:0] dma_buf_reg;
   logic dma_buf_valid_reg, dma_need, need_any;
   logic [1:0] need_bank;
   logic [3:0] push_be;
   logic push_half;
   mem_state_e mem_state_reg;
   logic [2:0] src_reg;
   wr_item_s push_item, pop_item;

   fifo_if #(.WIDTH($bits(wr_item_s))) wq ();

   word_fifo #(.WIDTH($bits(wr_item_s)), .DEPTH(FIFO_DEPTH)) u_write_queue (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .q(wq)
   );

   // Every pin, bus lines included, is re-timed so that a value counts only once stable.
   assign pin_raw = {dma_grant_in, wr_n_in, rd_n_in, cs_n_in, data_in, addr_in};
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_reg <= PIN_IDLE;
         s2_reg <= PIN_IDLE;
         s3_reg <= PIN_IDLE;
      end else begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   for (genvar i = 0; i < PIN_W; i++) begin : g_filt
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            filt_reg[i] <= PIN_IDLE[i];
         end else if (s2_reg[i] == s3_reg[i]) begin
            filt_reg[i] <= s2_reg[i];
         end
      end
   end

   assign f_addr = filt_reg[17:0];
   assign f_data = filt_reg[49:18];
   assign rd_act = !filt_reg[51];
   assign wr_act = !filt_reg[52];
   assign bus32 = platform_reg[BUS32_BIT]; // [RULE1]
   assign grant_act = (filt_reg[53] == platform_reg[DMA_GRANT_POL_BIT]); // [RULE14]
   assign pio_sel = !filt_reg[50] && !grant_act; // [RULE4]
   assign step = bus32 ? STEP32 : STEP16;
   assign bank = f_addr[17:16];
   assign mem_space = (f_addr[15:0] >= MEM_SPACE_BASE); // [RULE7]
   assign reg_ofs = {f_addr[15:2], 2'b00}; // [RULE10]

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_prev_reg <= 1'b0;
         wr_prev_reg <= 1'b0;
      end else begin
         rd_prev_reg <= rd_act;
         wr_prev_reg <= wr_act;
      end
   end
   assign rd_start = rd_act && !rd_prev_reg;
   assign wr_start = wr_act && !wr_prev_reg;
   assign pio_rd_mem = rd_start && pio_sel && mem_space;
   assign pio_rd_reg = rd_start && pio_sel && !mem_space;
   assign pio_wr_mem = wr_start && pio_sel && mem_space;
   assign pio_wr_reg = wr_start && pio_sel && !mem_space;

   // A 16-bit register write lands only with its upper half.
   assign reg_wr_en = pio_wr_reg && (bus32 || f_addr[1]); // [RULE3]
   assign reg_wr_data = bus32 ? f_data : {f_data[15:0], hold_reg};
   assign reg_wr_ofs = reg_ofs;
   assign dma_go = reg_wr_en && reg_wr_ofs == DMA_CFG_OFS && reg_wr_data[DMA_EN_BIT];
   assign dma_abort = reg_wr_en && reg_wr_ofs == DMA_CFG_OFS && !reg_wr_data[DMA_EN_BIT];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         platform_reg <= PLATFORM_RST;
         dma_cfg_reg <= DMA_CFG_RST;
         dma_start_reg <= '0;
         pf_cfg_reg <= '0;
         hold_reg <= '0;
      end else begin
         if (pio_wr_reg && !bus32 && !f_addr[1]) begin
            hold_reg <= f_data[15:0]; // [RULE3]
         end
         if (reg_wr_en) begin
            unique case (reg_wr_ofs)
               PLATFORM_OFS: platform_reg <= reg_wr_data;
               DMA_CFG_OFS: dma_cfg_reg <= reg_wr_data; // [RULE18]
               DMA_START_OFS: dma_start_reg <= reg_wr_data[15:0];
               PREFETCH_OFS: pf_cfg_reg <= reg_wr_data[17:0];
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      unique case (reg_ofs)
         PLATFORM_OFS: reg_rdata = platform_reg;
         INT_STATUS_OFS: reg_rdata = int_status_reg;
         DMA_CFG_OFS: reg_rdata = dma_cfg_reg;
         DMA_START_OFS: reg_rdata = {16'h0000, dma_start_reg};
         DMA_STATUS_OFS: reg_rdata = {dma_left_reg, 14'h0000, req_on_reg, dma_armed_reg};
         PREFETCH_OFS: reg_rdata = {14'h0000, pf_cfg_reg};
         default: reg_rdata = 32'h0000_0000;
      endcase
   end

   // Each bank owns a pointer and one prefetched double word.
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      logic fill_ok;
      assign fill_ok = mem_state_reg == MEM_WAIT && mem_ack_in && !mem_we_out
         && src_reg == 3'(b) && mem_addr_out[15:2] == pf_ptr_reg[b][15:2];
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            pf_ptr_reg[b] <= '0;
            pf_data_reg[b] <= '0;
            pf_valid_reg[b] <= 1'b0;
            pf_loaded_reg[b] <= 1'b0;
         end else if (reg_wr_en && reg_wr_ofs == PREFETCH_OFS && reg_wr_data[17:16] == 2'(b)) begin
            pf_ptr_reg[b] <= {reg_wr_data[15:1], 1'b0}; // [RULE6]
            pf_loaded_reg[b] <= 1'b1;
            pf_valid_reg[b] <= 1'b0;
         end else if (pio_rd_mem && bank == 2'(b)) begin
            pf_ptr_reg[b] <= pf_ptr_reg[b] + step; // [RULE6] [RULE8]
            if (bus32 || pf_ptr_reg[b][1]) begin
               pf_valid_reg[b] <= 1'b0;
            end
         end else if (fill_ok) begin
            pf_data_reg[b] <= mem_rdata_in;
            pf_valid_reg[b] <= 1'b1;
         end
      end
   end

   always_comb begin
      need_any = 1'b0;
      need_bank = 2'b00;
      for (int b = BANKS - 1; b >= 0; b--) begin
         if (pf_loaded_reg[b] && !pf_valid_reg[b]) begin
            need_any = 1'b1;
            need_bank = 2'(b);
         end
      end
   end

   // DMA engine: bursts are counted in bus cycles, twice as many on a 16-bit bus.
   assign dma_dir_rd = dma_cfg_reg[DMA_DIR_BIT];
   always_comb begin
      unique case (dma_cfg_reg[BURST_LSB +: 2])
         2'd0: burst_cycles = BURST_1;
         2'd1: burst_cycles = BURST_4;
         2'd2: burst_cycles = BURST_8;
         2'd3: burst_cycles = BURST_16;
      endcase
      if (!bus32) begin
         burst_cycles = {burst_cycles[4:0], 1'b0}; // [RULE11] [RULE18]
      end
   end
   assign dma_beat = dma_armed_reg && grant_act && (dma_dir_rd ? rd_start : wr_start); // [RULE4]
   assign last_in_burst = (dma_beat_reg + 6'h01) == burst_cycles;
   assign dma_final = dma_left_reg <= step;
   assign dma_take = dma_final ? dma_left_reg : step;
   assign dma_need = dma_armed_reg && dma_dir_rd && !dma_buf_valid_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dma_ptr_reg <= '0;
         dma_left_reg <= '0;
         dma_armed_reg <= 1'b0;
         dma_beat_reg <= '0;
      end else if (dma_go) begin
         dma_ptr_reg <= {dma_start_reg[15:1], 1'b0};
         dma_left_reg <= reg_wr_data[LEN_LSB +: 16];
         dma_armed_reg <= (reg_wr_data[LEN_LSB +: 16] != '0);
         dma_beat_reg <= '0;
      end else if (dma_abort) begin
         dma_armed_reg <= 1'b0;
      end else if (dma_beat) begin
         dma_ptr_reg <= dma_ptr_reg + step;
         dma_left_reg <= dma_left_reg - dma_take;
         dma_beat_reg <= last_in_burst ? 6'h00 : dma_beat_reg + 6'h01;
         if (dma_final) begin
            dma_armed_reg <= 1'b0; // [RULE13]
         end
      end else if (!grant_act) begin
         dma_beat_reg <= '0; // [RULE15]
      end
   end

   always_comb begin
      req_on_next = req_on_reg;
      if (dma_go) begin
         req_on_next = (reg_wr_data[LEN_LSB +: 16] != '0); // [RULE20]
      end else if (dma_abort) begin
         req_on_next = 1'b0;
      end else if (dma_beat && (last_in_burst || dma_final)) begin
         req_on_next = 1'b0; // [RULE12] [RULE13]
      end else if (dma_armed_reg && !grant_act
                   && (dma_dir_rd ? dma_buf_valid_reg : wq.push_ready)) begin
         req_on_next = 1'b1; // [RULE12]
      end
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         req_on_reg <= 1'b0;
         dma_request_out <= DMA_REQUEST_PIN_RST;
      end else begin
         req_on_reg <= req_on_next;
         dma_request_out <= req_on_next ~^ platform_reg[DMA_REQUEST_POL_BIT]; // [RULE14]
      end
   end

   // The done flag is sticky; a new completion beats a clear in the same cycle.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         int_status_reg <= '0;
      end else if (dma_beat && dma_final) begin // [RULE23]
         int_status_reg[DONE_BIT] <= 1'b1; // [RULE17]
      end else if (reg_wr_en && reg_wr_ofs == INT_STATUS_OFS && reg_wr_data[DONE_BIT]) begin
         int_status_reg[DONE_BIT] <= 1'b0;
      end
   end
   assign dma_done_event_flag_out = int_status_reg[DONE_BIT];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dma_buf_reg <= '0;
         dma_buf_valid_reg <= 1'b0;
      end else if (dma_go || (dma_beat && dma_dir_rd && (bus32 || dma_ptr_reg[1]))) begin
         dma_buf_valid_reg <= 1'b0;
      end else if (mem_state_reg == MEM_WAIT && mem_ack_in && !mem_we_out && src_reg == SRC_DMA
                   && mem_addr_out[15:2] == dma_ptr_reg[15:2]) begin
         dma_buf_reg <= mem_rdata_in;
         dma_buf_valid_reg <= 1'b1;
      end
   end

   // PIO writes take the bus address each cycle, DMA writes the DMA pointer; only the final DMA beat may trim lanes.
   assign push_half = (dma_beat ? dma_ptr_reg[1] : f_addr[1]);
   always_comb begin
      push_be = bus32 ? 4'hF : (push_half ? 4'hC : 4'h3);
      if (dma_beat && dma_left_reg < step) begin
         if (bus32) begin
            push_be = (dma_left_reg[1:0] == 2'd1) ? 4'h1
               : (dma_left_reg[1:0] == 2'd2) ? 4'h3 : 4'h7; // [RULE19]
         end else begin
            push_be = push_half ? 4'h4 : 4'h1; // [RULE19]
         end
      end
   end
   assign push_item.addr = dma_beat ? {dma_ptr_reg[15:2], 2'b00} : {f_addr[15:2], 2'b00}; // [RULE9]
   assign push_item.be = push_be;
   assign push_item.data = bus32 ? f_data
      : (push_half ? {f_data[15:0], 16'h0000} : {16'h0000, f_data[15:0]});
   assign wq.push_valid = pio_wr_mem || (dma_beat && !dma_dir_rd); // [RULE22]
   assign wq.push_data = push_item;
   assign pop_item = wr_item_s'(wq.pop_data);
   assign wq.pop_ready = (mem_state_reg == MEM_IDLE);

   // Queued writes go first so a later prefetch never overtakes them.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mem_state_reg <= MEM_IDLE;
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= '0;
         mem_wdata_out <= '0;
         mem_be_out <= '0;
         src_reg <= '0;
      end else begin
         unique case (mem_state_reg)
            MEM_IDLE: begin
               if (wq.pop_valid) begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b1;
                  mem_addr_out <= pop_item.addr;
                  mem_wdata_out <= pop_item.data;
                  mem_be_out <= pop_item.be;
                  mem_state_reg <= MEM_WAIT;
               end else if (dma_need || need_any) begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b0;
                  mem_be_out <= 4'hF;
                  mem_addr_out <= dma_need ? {dma_ptr_reg[15:2], 2'b00}
                     : {pf_ptr_reg[need_bank][15:2], 2'b00};
                  src_reg <= dma_need ? SRC_DMA : {1'b0, need_bank};
                  mem_state_reg <= MEM_WAIT;
               end
            end
            MEM_WAIT: begin
               if (mem_ack_in) begin
                  mem_req_out <= 1'b0;
                  mem_we_out <= 1'b0;
                  mem_state_reg <= MEM_IDLE;
               end
            end
         endcase
      end
   end

   // Read data is chosen at the leading edge and held while the strobe stays.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         data_out <= '0;
         data_oe_out <= 1'b0;
         snap_reg <= '0;
      end else begin
         data_oe_out <= rd_act && (!filt_reg[50] || grant_act); // [RULE4]
         if (dma_beat && dma_dir_rd) begin
            data_out <= bus32 ? dma_buf_reg : {16'h0000,
               dma_ptr_reg[1] ? dma_buf_reg[31:16] : dma_buf_reg[15:0]};
         end else if (pio_rd_mem) begin
            data_out <= bus32 ? pf_data_reg[bank] : {16'h0000,
               pf_ptr_reg[bank][1] ? pf_data_reg[bank][31:16] : pf_data_reg[bank][15:0]}; // [RULE8]
         end else if (pio_rd_reg) begin
            if (bus32) begin
               data_out <= reg_rdata; // [RULE10]
            end else if (!f_addr[1]) begin
               data_out <= {16'h0000, reg_rdata[15:0]};
               snap_reg <= reg_rdata[31:16]; // [RULE3]
            end else begin
               data_out <= {16'h0000, snap_reg};
            end
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_pf_advance;
      pio_rd_mem |=> pf_ptr_reg[$past(bank)] == $past(pf_ptr_reg[bank]) + $past(step);
   endproperty
   a_pf_advance: assert property (p_pf_advance) else $error("Bank pointer did not advance."); // [RULE6]
   property p_reg_no_pf;
      pio_rd_reg |=> $stable(pf_ptr_reg[0]) && $stable(pf_ptr_reg[1])
         && $stable(pf_ptr_reg[2]) && $stable(pf_ptr_reg[3]);
   endproperty
   a_reg_no_pf: assert property (p_reg_no_pf) else $error("Register read moved a pointer."); // [RULE7]
   property p_burst_drop;
      dma_beat && last_in_burst && !dma_go |=> !req_on_reg ##1 (!req_on_reg || !grant_act);
   endproperty
   a_burst_drop: assert property (p_burst_drop) else $error("Request held past burst end."); // [RULE12]
   property p_stay_off;
      !dma_armed_reg && !dma_go |=> !req_on_reg;
   endproperty
   a_stay_off: assert property (p_stay_off) else $error("Request raised while idle."); // [RULE13]
   property p_pin_level;
      $rose(req_on_reg) |-> dma_request_out == $past(platform_reg[DMA_REQUEST_POL_BIT]);
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("Request pin polarity wrong."); // [RULE14]
   property p_pio_keeps_dma;
      (rd_start || wr_start) && !grant_act && !dma_go && !dma_abort
         |=> $stable(dma_ptr_reg) && $stable(dma_left_reg);
   endproperty
   a_pio_keeps_dma: assert property (p_pio_keeps_dma) else $error("PIO changed DMA state."); // [RULE15]
   property p_done_flag;
      dma_beat && dma_final |=> dma_done_event_flag_out [*2];
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("Done flag not set."); // [RULE17]
   property p_go_request;
      dma_go && reg_wr_data[LEN_LSB +: 16] != '0 |=> req_on_reg && dma_armed_reg;
   endproperty
   a_go_request: assert property (p_go_request) else $error("Enable did not raise request."); // [RULE20]
   property p_half_write;
      pio_wr_reg && !bus32 && !f_addr[1] |=> $stable(platform_reg) && $stable(dma_cfg_reg);
   endproperty
   a_half_write: assert property (p_half_write) else $error("Half register write committed."); // [RULE3]
   property p_odd_bytes;
      dma_beat && !dma_dir_rd && dma_left_reg == 16'h0001 |-> $countones(push_be) == 1;
   endproperty
   a_odd_bytes: assert property (p_odd_bytes) else $error("Odd tail wrote extra bytes."); // [RULE19]
   c_burst_done: cover property (dma_beat && last_in_burst && !dma_final);
   c_dma_end: cover property (dma_beat && dma_final);
   c_interleave: cover property (pio_rd_mem && bank == 2'b01 ##[1:50] pio_rd_mem && bank == 2'b10);
   c_queue_full: cover property (!wq.push_ready);
endmodule : host_memory_access_port

/* tb/mem_model.sv */
`timescale 1ns/1ps
module mem_model (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [15:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] be_in,
   output logic ack_out,
   output logic [31:0] rdata_out
);
   logic [31:0] mem [0:16383];
   logic [1:0] cnt_reg;
   initial begin
      {ack_out, cnt_reg, rdata_out} = '0;
      for (int i = 0; i < 16384; i++) mem[i] = {16'h5A5A, 16'(i * 4)};
   end
   // Words at odd dword slots answer late, so a slow memory is met as well.
   always @(posedge clk_in) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
         cnt_reg <= cnt_reg + 2'h1;
         if (cnt_reg >= {addr_in[2], 1'b0}) begin
            cnt_reg <= 2'h0;
            ack_out <= 1'b1;
            rdata_out <= mem[addr_in[15:2]];
            for (int b = 0; b < 4; b++) begin
               if (we_in && be_in[b]) mem[addr_in[15:2]][b*8+:8] <= wdata_in[b*8+:8];
            end
         end
      end
   end
endmodule : mem_model

/* tb/tb_host_memory_access_port.sv */
`timescale 1ns/1ps
module tb_host_memory_access_port;
   import hmap_pkg::*;
   logic clk_in = 0, rst_in = 1, cs_n_in = 1, rd_n_in = 1, wr_n_in = 1, dma_grant_in = 1;
   logic [ADDR_W-1:0] addr_in = '0;
   logic [DATA_W-1:0] data_in = '0, data_out, mem_rdata_in, mem_wdata_out, q;
   logic data_oe_out, dma_request_out, dma_done_event_flag_out, mem_req_out, mem_we_out;
   logic mem_ack_in, bus32 = 0, pol = 0;
   logic [MEM_AW-1:0] mem_addr_out;
   logic [3:0] mem_be_out;
   int mismatches = 0, tests_run = 0, cycles = 0;
   host_memory_access_port host_memory_access_port_inst (.clk_in(clk_in), .rst_in(rst_in),
      .addr_in(addr_in), .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
      .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .dma_grant_in(dma_grant_in),
      .dma_request_out(dma_request_out), .dma_done_event_flag_out(dma_done_event_flag_out),
      .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_be_out(mem_be_out), .mem_ack_in(mem_ack_in),
      .mem_rdata_in(mem_rdata_in));
   mem_model mem_model_inst (.clk_in(clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .be_in(mem_be_out),
      .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
   initial begin
      forever #25 clk_in = ~clk_in;
   end
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   // The run needs well under a thousand cycles; the ceiling leaves a wide margin.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   function automatic logic [31:0] pat(input logic [15:0] a);
      return {16'h5A5A, a};
   endfunction : pat
   // No ready pin exists, so each strobe is held long enough to cover the pin synchronisers.
   task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d, input logic dma);
      @(negedge clk_in);
      addr_in = a;
      data_in = bus32 ? d : {16'hFFFF, d[15:0]};
      {cs_n_in, dma_grant_in, wr_n_in, rd_n_in} = {dma, dma == pol, !w, w};
      repeat (9) @(posedge clk_in);
      q = data_out;
      chk("oe", 32'(data_oe_out), 32'(!w));
      if (dma) chk("req", 32'(dma_request_out), 32'h0);
      @(negedge clk_in);
      {cs_n_in, dma_grant_in, wr_n_in, rd_n_in} = {1'b1, !pol, 2'b11};
      data_in = ~data_in;
      repeat (6) @(negedge clk_in);
   endtask : acc
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 1'b0);
   endtask : wr
   task automatic rd(input logic [17:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0000_0000, 1'b0);
      chk("rdata", q, e);
   endtask : rd
   task automatic wait_req();
      for (int n = 0; n < 40 && dma_request_out !== 1'b1; n++) @(negedge clk_in);
      chk("req", 32'(dma_request_out), 32'h1);
   endtask : wait_req
   initial begin
      repeat (4) @(posedge clk_in);
      chk("req", 32'(dma_request_out), 32'h1);
      chk("done", 32'(dma_done_event_flag_out), 32'h0);
      @(negedge clk_in);
      rst_in = 1'b0;
      repeat (6) @(negedge clk_in);
      wr(18'h0_0300, 32'h0000_0160);
      wr(18'h0_0302, 32'h0000_0000);
      {bus32, pol, dma_grant_in} = 3'b110;
      chk("req", 32'(dma_request_out), 32'h0);
      rd(18'h0_0300, 32'h0000_0160);
      rd(18'h0_03F0, 32'h0000_0000);
      wr(18'h0_4000, 32'hCAFE_0001);
      wr(18'h0_4004, 32'hCAFE_0002);
      wr(18'h0_033C, 32'h0001_4000);
      rd(18'h1_9990, 32'hCAFE_0001);
      rd(18'h1_0300, 32'h0000_0160);
      rd(18'h1_8888, 32'hCAFE_0002);
      wr(18'h0_033C, 32'h0002_4100);
      rd(18'h2_4000, pat(16'h4100));
      rd(18'h1_4000, pat(16'h4008));
      rd(18'h2_4000, pat(16'h4104));
      wr(18'h0_0334, 32'h0000_5000);
      wr(18'h0_0330, 32'h0007_0002);
      chk("req", 32'(dma_request_out), 32'h1);
      acc(1'b1, 18'h0_0000, 32'h1122_3344, 1'b1);
      rd(18'h0_0300, 32'h0000_0160);
      wait_req();
      acc(1'b1, 18'h0_0000, 32'h5566_7788, 1'b1);
      repeat (20) @(negedge clk_in);
      chk("req", 32'(dma_request_out), 32'h0);
      chk("done", 32'(dma_done_event_flag_out), 32'h1);
      wr(18'h0_033C, 32'h0003_5000);
      rd(18'h3_5000, 32'h1122_3344);
      rd(18'h3_5000, 32'h5A66_7788);
      wr(18'h0_0330, 32'h0004_0003);
      acc(1'b0, 18'h0_0000, 32'h0000_0000, 1'b1);
      chk("dma_rdata", q, 32'h1122_3344);
      wr(18'h0_0310, 32'h0000_0008);
      chk("done", 32'(dma_done_event_flag_out), 32'h0);
      final_report();
   end
endmodule : tb_host_memory_access_port
